/* hw/osd_pkg.sv */
// Constants, register map and state encoding for the output sync and divider block.
package osd_pkg;

  // Clock rate and sync re-enable delay.
  localparam int CLK_MHZ = 40;
  localparam int SYNC_DELAY_NS = 6000;
  localparam int SYNC_DELAY_CYC = (SYNC_DELAY_NS * CLK_MHZ) / 1000;
  localparam logic [7:0] SYNC_DELAY_CNT = 8'(SYNC_DELAY_CYC - 1);

  // Bus geometry.
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int DIV_W = 8;
  localparam int NUM_OUT = 5;

  // Register byte offsets.
  localparam logic [ADDR_W-1:0] REG_CTRL = 8'h00;
  localparam logic [ADDR_W-1:0] REG_INDIV = 8'h04;
  localparam logic [ADDR_W-1:0] REG_OUTDIV0 = 8'h08;
  localparam logic [ADDR_W-1:0] REG_STRIDE = 8'h04;
  localparam logic [ADDR_W-1:0] REG_STATUS = 8'h1c;

  // Control register fields.
  localparam int CTRL_SYNC = 0;
  localparam int CTRL_NODELAY = 1;
  localparam int CTRL_MUXONLY = 2;
  localparam int CTRL_MUXSRC = 3;
  localparam int CTRL_AUXEN = 4;
  localparam int CTRL_AUXSEL = 5;
  localparam int CTRL_W = 6;

  // Status register fields.
  localparam int STAT_ON = 0;
  localparam int STAT_WAIT = 1;
  localparam int STAT_AUX = 2;
  localparam int STAT_SYNCPIN = 3;

  // Reset values.
  localparam logic [CTRL_W-1:0] CTRL_RST = 6'h00;
  localparam logic [DIV_W-1:0] DIV_RST = 8'h00;

  // Aux source dividers.
  localparam int AUX_SRC0 = 2;
  localparam int AUX_SRC1 = 3;

  // Sampled pin indices.
  localparam int PIN_SYNC = 0;
  localparam int PIN_REF = 1;
  localparam int PIN_SYNTHESIZED_CLOCK = 2;
  localparam int NUM_PIN = 3;

  typedef enum logic [1:0] {
    ST_OFF = 2'b00,
    ST_DELAY = 2'b01,
    ST_ALIGN = 2'b10,
    ST_ON = 2'b11
  } osd_state_e;

endpackage : osd_pkg

/* hw/osd_output_sync.sv */
// Output synchronization, auxiliary output select and input divider.
//
// The Avalon-MM slave port and the register addresses are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none

// Function
// - Sync pin rise or sync bit rise starts a sync; an output divider change restarts one unless the sequencer is in ST_OFF.
// - Rise, both selects 0: wait 6 us, enable on coincident ref and mux edges.
// - Rise, selects 0 then 1: wait 6 us, enable on next mux clock edge.
// - Rise, selects 1 then 0: enable at once on coincident ref and mux edges.
// - Rise, both selects 1: enable at once on next mux clock edge.
// - Falling sync pin or sync bit disables all outputs whatever the selects.
// - Aux output off unless enabled; source select picks divider 2 or 3.
// - Aux output stays off if its selected divider divides by one.
// - Synthesized clock is placed on the distribution bus as a mux source.
// - Input divider divides the reference clock pin and feeds the phase detector.
// - Input divide ratio is the 8-bit field plus one, 1 to 256.
module osd_output_sync (
  // Clock and reset
  input wire logic clk,
  input wire logic nrst,
  // Avalon-MM slave
  input wire logic [osd_pkg::ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [osd_pkg::DATA_W-1:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [osd_pkg::DATA_W-1:0] avs_readdata,
  output logic avs_waitrequest,
  // Pins from outside the clock domain
  input wire logic sync_pin,
  input wire logic ref_clk_pin,
  input wire logic synthesized_clock_clk_pin,
  // Clock outputs
  output logic [osd_pkg::NUM_OUT-1:0] out_clk,
  output logic auxiliary_clock_out,
  output logic synthesized_clock,
  output logic pfd_clk
);
  import osd_pkg::*;

  function automatic logic is_div1(input logic [DIV_W-1:0] field);
    is_div1 = (field == DIV_RST);
  endfunction : is_div1

  logic [NUM_PIN-1:0] pin_in;
  logic [NUM_PIN-1:0] pin_s1;
  logic [NUM_PIN-1:0] pin_s2;
  logic [NUM_PIN-1:0] pin_s3;
  logic [NUM_PIN-1:0] pin_stable;
  logic [NUM_PIN-1:0] pin_rise;
  logic [NUM_PIN-1:0] pin_fall;

  logic [CTRL_W-1:0] ctrl;
  logic [DIV_W-1:0] input_divide_field;
  logic [DIV_W-1:0] out_div [NUM_OUT];
  logic sync_bit_q;
  logic ack;
  logic aux_active;
  osd_state_e state;
  osd_state_e next_state;
  logic [7:0] dly_cnt;
  logic [DIV_W-1:0] in_cnt;
  logic [DIV_W-1:0] out_cnt [NUM_OUT];

  assign pin_in[PIN_SYNC] = sync_pin;
  assign pin_in[PIN_REF] = ref_clk_pin;
  assign pin_in[PIN_SYNTHESIZED_CLOCK] = synthesized_clock_clk_pin;

  // Three-stage sampling; a level counts once stages two and three agree.
  genvar g;
  generate
    for (g = 0; g < NUM_PIN; g++)
    begin : g_pin
      always_ff @(posedge clk or negedge nrst)
      begin
        if (!nrst)
        begin
          pin_s1[g] <= 1'b0;
          pin_s2[g] <= 1'b0;
          pin_s3[g] <= 1'b0;
          pin_stable[g] <= 1'b0;
        end
        else
        begin
          pin_s1[g] <= pin_in[g];
          pin_s2[g] <= pin_s1[g];
          pin_s3[g] <= pin_s2[g];
          if (pin_s2[g] == pin_s3[g])
          begin
            pin_stable[g] <= pin_s3[g];
          end
        end
      end
      assign pin_rise[g] = (pin_s2[g] == pin_s3[g]) && pin_s3[g] && !pin_stable[g];
      assign pin_fall[g] = (pin_s2[g] == pin_s3[g]) && !pin_s3[g] && pin_stable[g];
    end
  endgenerate

  // Bus decode.
  wire req = avs_read || avs_write;
  wire wr_fire = avs_write && ack && avs_byteenable[0];
  wire hit_ctrl = (avs_address == REG_CTRL);
  wire hit_indiv = (avs_address == REG_INDIV);
  wire hit_status = (avs_address == REG_STATUS);
  wire [NUM_OUT-1:0] hit_out;
  wire [NUM_OUT-1:0] out_changed;

  // One wait cycle keeps read data registered while the decode settles.
  assign avs_waitrequest = req && !ack;

  // Clock selection for the output mux.
  wire mux_src_synthesized_clock = ctrl[CTRL_MUXSRC];
  wire mux_rise = mux_src_synthesized_clock ? pin_rise[PIN_SYNTHESIZED_CLOCK] : pin_rise[PIN_REF];
  wire mux_level = mux_src_synthesized_clock ? pin_stable[PIN_SYNTHESIZED_CLOCK] : pin_stable[PIN_REF];
  wire outputs_on = (state == ST_ON);

  // Sync bit edges come from software writes to the control register.
  wire next_sync_bit = ctrl[CTRL_SYNC];
  wire bit_rise = next_sync_bit && !sync_bit_q;
  wire bit_fall = !next_sync_bit && sync_bit_q;
  wire sync_rise = pin_rise[PIN_SYNC] || bit_rise;
  wire sync_fall = pin_fall[PIN_SYNC] || bit_fall;
  wire div_restart = |out_changed;

  generate
    for (g = 0; g < NUM_OUT; g++)
    begin : g_dec
      assign hit_out[g] = (avs_address == REG_OUTDIV0 + ADDR_W'(g) * REG_STRIDE);
      assign out_changed[g] = wr_fire && hit_out[g]
        && (avs_writedata[DIV_W-1:0] != out_div[g]);
    end
  endgenerate

  logic [DATA_W-1:0] rd_word;
  always_comb
  begin
    rd_word = '0;
    if (hit_ctrl)
      rd_word[CTRL_W-1:0] = ctrl;
    if (hit_indiv)
      rd_word[DIV_W-1:0] = input_divide_field;
    for (int i = 0; i < NUM_OUT; i++)
      if (hit_out[i])
        rd_word[DIV_W-1:0] = out_div[i];
    if (hit_status)
    begin
      rd_word[STAT_ON] = outputs_on;
      rd_word[STAT_WAIT] = (state == ST_DELAY) || (state == ST_ALIGN);
      rd_word[STAT_AUX] = aux_active;
      rd_word[STAT_SYNCPIN] = pin_stable[PIN_SYNC];
    end
  end

  // Bus handshake and register writes.
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      ack <= 1'b0;
      avs_readdata <= '0;
      ctrl <= CTRL_RST;
      input_divide_field <= DIV_RST;
      sync_bit_q <= 1'b0;
    end
    else
    begin
      ack <= req && !ack;
      sync_bit_q <= next_sync_bit;
      if (avs_read && !ack)
        avs_readdata <= rd_word;
      if (wr_fire && hit_ctrl)
        ctrl <= avs_writedata[CTRL_W-1:0];
      if (wr_fire && hit_indiv)
        input_divide_field <= avs_writedata[DIV_W-1:0];
    end
  end

  generate
    for (g = 0; g < NUM_OUT; g++)
    begin : g_reg
      always_ff @(posedge clk or negedge nrst)
      begin
        if (!nrst)
        begin
          out_div[g] <= DIV_RST;
        end
        else if (wr_fire && hit_out[g])
        begin
          out_div[g] <= avs_writedata[DIV_W-1:0];
        end
      end
    end
  endgenerate

  // Sync sequencer. A falling edge beats a rise in the same cycle.
  wire skip_delay = ctrl[CTRL_NODELAY];
  wire mux_only = ctrl[CTRL_MUXONLY];
  wire start_state_delay = !skip_delay;
  wire align_hit = mux_only ? mux_rise : (mux_rise && pin_rise[PIN_REF]);

  always_comb
  begin
    next_state = state;
    unique case (state)
      ST_OFF:
      begin
        if (sync_rise)
          next_state = start_state_delay ? ST_DELAY : ST_ALIGN;
      end
      ST_DELAY:
      begin
        if (dly_cnt == '0)
          next_state = ST_ALIGN;
      end
      ST_ALIGN:
      begin
        if (align_hit)
          next_state = ST_ON;
      end
      ST_ON:
      begin
        next_state = ST_ON;
      end
    endcase
    if ((state != ST_OFF) && (sync_rise || div_restart))
    begin
      next_state = start_state_delay ? ST_DELAY : ST_ALIGN;
    end
    if (sync_fall)
    begin
      next_state = ST_OFF;
    end
  end

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      state <= ST_OFF;
      dly_cnt <= '0;
    end
    else
    begin
      state <= next_state;
      if (next_state == ST_DELAY && (state != ST_DELAY || next_state != state
          || sync_rise || div_restart))
      begin
        dly_cnt <= SYNC_DELAY_CNT;
      end
      else if (dly_cnt != '0)
      begin
        dly_cnt <= dly_cnt - 8'h01;
      end
    end
  end

  // Output dividers run only while the outputs are enabled, so each resync restarts phase.
  generate
    for (g = 0; g < NUM_OUT; g++)
    begin : g_div
      wire [DIV_W:0] half = ({1'b0, out_div[g]} + 9'h001) >> 1;
      always_ff @(posedge clk or negedge nrst)
      begin
        if (!nrst)
        begin
          out_cnt[g] <= '0;
          out_clk[g] <= 1'b0;
        end
        else if (!outputs_on)
        begin
          out_cnt[g] <= '0;
          out_clk[g] <= 1'b0;
        end
        else
        begin
          if (mux_rise)
          begin
            out_cnt[g] <= (out_cnt[g] == out_div[g]) ? '0 : out_cnt[g] + 8'h01;
          end
          out_clk[g] <= is_div1(out_div[g]) ? mux_level : ({1'b0, out_cnt[g]} < half);
        end
      end
    end
  endgenerate

  // Auxiliary output select.
  wire aux_sel = ctrl[CTRL_AUXSEL];
  wire [DIV_W-1:0] aux_field = aux_sel ? out_div[AUX_SRC1] : out_div[AUX_SRC0];
  wire aux_src_clk = aux_sel ? out_clk[AUX_SRC1] : out_clk[AUX_SRC0];
  assign aux_active = ctrl[CTRL_AUXEN] && !is_div1(aux_field);

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      auxiliary_clock_out <= 1'b0;
      synthesized_clock <= 1'b0;
      pfd_clk <= 1'b0;
      in_cnt <= '0;
    end
    else
    begin
      auxiliary_clock_out <= aux_active && aux_src_clk;
      synthesized_clock <= pin_stable[PIN_SYNTHESIZED_CLOCK];
      pfd_clk <= 1'b0;
      if (pin_rise[PIN_REF])
      begin
        if (in_cnt == input_divide_field)
        begin
          in_cnt <= '0;
          pfd_clk <= 1'b1;
        end
        else
        begin
          in_cnt <= in_cnt + 8'h01;
        end
      end
    end
  end

endmodule : osd_output_sync

`default_nettype wire

/* dv/osd_chk.sv */
// Port-level assertions for the output sync block.
`timescale 1ns/1ps
`default_nettype none
module osd_chk (
  // Clock and reset
  input wire logic clk,
  input wire logic nrst,
  // Register bus
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [osd_pkg::DATA_W-1:0] avs_readdata,
  input wire logic avs_waitrequest,
  // Pins and clock outputs
  input wire logic sync_pin,
  input wire logic synthesized_clock_clk_pin,
  input wire logic [osd_pkg::NUM_OUT-1:0] out_clk,
  input wire logic synthesized_clock,
  input wire logic pfd_clk
);
  import osd_pkg::*;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!nrst);
  wire req = avs_read | avs_write;
  a_wait_first: assert property ($rose(req) |-> avs_waitrequest)
    else $error("new request answered without a wait cycle");
  a_wait_answer: assert property (req && avs_waitrequest ##1 req |-> !avs_waitrequest)
    else $error("request not answered after one wait cycle");
  a_wait_idle: assert property (!req |-> !avs_waitrequest)
    else $error("wait raised with no request");
  a_read_upper: assert property (avs_readdata[DATA_W-1:8] == '0)
    else $error("read data upper bits not zero");
  a_read_stands: assert property (!avs_read |=> $stable(avs_readdata))
    else $error("read data changed without a read");
  a_pfd_single: assert property (pfd_clk |=> !pfd_clk)
    else $error("phase detector pulse longer than one cycle");
  a_synthesized_clock_high: assert property (synthesized_clock_clk_pin [*6] |-> synthesized_clock)
    else $error("synthesized clock not following high level");
  a_synthesized_clock_low: assert property (!synthesized_clock_clk_pin [*6] |-> !synthesized_clock)
    else $error("synthesized clock not following low level");
  a_pin_fall_off: assert property ($fell(sync_pin) ##1 !sync_pin [*8] |-> out_clk == '0)
    else $error("outputs still running after sync pin fall");
  cover property (out_clk != '0);
  cover property (pfd_clk);
  cover property ($fell(sync_pin));
endmodule : osd_chk
bind osd_output_sync osd_chk osd_chk_inst (.clk, .nrst, .avs_read, .avs_write, .avs_readdata,
  .avs_waitrequest, .sync_pin, .synthesized_clock_clk_pin, .out_clk, .synthesized_clock, .pfd_clk);
`default_nettype wire

/* dv/tb_top.sv */
// Self-checking testbench for the output sync block.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import osd_pkg::*;
  logic clk = 0, nrst = 0, avs_read = 0, avs_write = 0;
  logic sync_pin = 0, ref_clk_pin = 0, synthesized_clock_clk_pin = 0;
  logic [ADDR_W-1:0] avs_address = '0;
  logic [DATA_W-1:0] avs_writedata = '0, avs_readdata, r;
  logic [3:0] avs_byteenable = 4'h1;
  logic avs_waitrequest, auxiliary_clock_out, synthesized_clock, pfd_clk;
  logic [NUM_OUT-1:0] out_clk;
  logic [DATA_W-1:0] exp_q[$];
  int n_errors = 0, total_checks = 0, ck = 0, n;
  always #12.5 clk = ~clk;
  osd_output_sync osd_output_sync_inst (.clk, .nrst, .avs_address, .avs_read, .avs_write,
    .avs_writedata, .avs_byteenable, .avs_readdata, .avs_waitrequest, .sync_pin, .ref_clk_pin,
    .synthesized_clock_clk_pin, .out_clk, .auxiliary_clock_out, .synthesized_clock, .pfd_clk);
  // Clocks tied to clk keep every expected edge count exact: ref 20 cycles, synthesized_clock 12.
  always @(posedge clk)
  begin
    ck <= ck + 1;
    if (ck % 10 == 9) ref_clk_pin <= ~ref_clk_pin;
    if (ck % 6 == 5) synthesized_clock_clk_pin <= ~synthesized_clock_clk_pin;
  end
  task chk(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      n_errors++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  always @(posedge clk)
    if (avs_read === 1'b1 && avs_waitrequest === 1'b0) chk(avs_readdata, exp_q.pop_front());
  task bus(input logic w, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= w;
    avs_read <= !w;
    do @(posedge clk); while (avs_waitrequest !== 1'b0);
    avs_read <= 0;
    avs_write <= 0;
    @(posedge clk);
  endtask : bus
  task rd(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] e);
    exp_q.push_back(e);
    bus(0, a, '0);
  endtask : rd
  task pfd_gap(input int f);
    bus(1, REG_INDIV, DATA_W'(f));
    repeat (2) do @(posedge clk); while (pfd_clk !== 1'b1);
    n = 0;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (pfd_clk !== 1'b1);
    chk(DATA_W'(n), DATA_W'((f + 1) * 20));
  endtask : pfd_gap
  task close_out;
    $display("checks %0d errors %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : close_out
  initial
  begin
    r = $urandom(32'h28ef203b);
    repeat (10) @(posedge clk);
    nrst <= 1;
    @(posedge clk);
    rd(REG_CTRL, '0);
    rd(REG_INDIV, '0);
    r = $urandom & 32'hfffffffe;
    bus(1, REG_CTRL, r);
    rd(REG_CTRL, r & 32'h3e);
    bus(1, REG_INDIV, r);
    rd(REG_INDIV, r & 32'hff);
    bus(1, 8'h40, r);
    rd(8'h40, '0);
    rd(REG_STATUS, '0);
    $display("test registers done");
    // Index bit 0 skips the delay, bit 1 aligns on the mux clock alone (synthesized_clock as source).
    for (int s = 0; s < 4; s++)
    begin
      r = DATA_W'(s[1] * 12 + s[0] * 2);
      bus(1, REG_CTRL, r);
      rd(REG_STATUS, '0);
      chk(DATA_W'(out_clk), '0);
      bus(1, REG_CTRL, r | 32'h1);
      if (!s[0])
      begin
        repeat (100) @(posedge clk);
        rd(REG_STATUS, 32'h2);
      end
      repeat (s[0] ? 40 : 200) @(posedge clk);
      rd(REG_STATUS, 32'h1);
    end
    $display("test select modes done");
    bus(1, REG_CTRL, 32'h1d);
    rd(REG_STATUS, 32'h1);
    bus(1, 8'h10, 32'h1);
    rd(REG_STATUS, 32'h6);
    repeat (300) @(posedge clk);
    rd(REG_STATUS, 32'h5);
    // The aux pin must toggle while active, so count its high cycles in a window.
    n = 0;
    repeat (60) @(posedge clk) n += auxiliary_clock_out;
    chk(DATA_W'(n > 0 && n < 60), 32'h1);
    bus(1, 8'h10, 32'h1);
    rd(REG_STATUS, 32'h5);
    bus(1, REG_CTRL, 32'h3d);
    rd(REG_STATUS, 32'h1);
    n = 0;
    repeat (60) @(posedge clk) n += auxiliary_clock_out;
    chk(DATA_W'(n), '0);
    $display("test divider and aux done");
    bus(1, REG_CTRL, 32'h2f);
    sync_pin <= 1;
    repeat (40) @(posedge clk);
    rd(REG_STATUS, 32'h9);
    sync_pin <= 0;
    repeat (40) @(posedge clk);
    rd(REG_STATUS, '0);
    chk(DATA_W'(out_clk), '0);
    sync_pin <= 1;
    repeat (40) @(posedge clk);
    rd(REG_STATUS, 32'h9);
    $display("test sync pin done");
    pfd_gap(0);
    pfd_gap(1 + $urandom % 3);
    pfd_gap(255);
    $display("test input divider done");
    close_out();
  end
  initial
  begin
    repeat (40000) @(posedge clk);
    n_errors++;
    close_out();
  end
endmodule : tb_top
`default_nettype wire
